/* low_power_mode_controller.v */
/*
 Low-power mode controller: sequences sleep, deep-sleep, power-down and
 deep power-down, gating processor, clocks, analog, flash and power.
 Assumes wake sources and the wake pin are asynchronous; the processor
 strobe and configuration ports come from logic on mclk.
*/
//
// Operation
// RULE1: Sleep halts processor until reset or interrupt; peripherals keep running.
// RULE2: Deep-sleep stops peripheral clocks and sources except RC and chosen watchdog.
// RULE3: Deep-sleep shuts analog blocks and puts flash in standby.
// RULE4: Deep-sleep exits on pin, watchdog, sync serial, SPI or bus-slave interrupt.
// RULE5: Interrupt wakes only if enabled in wake enable and interrupt controller.
// RULE6: Power-down stops all clocks except chosen watchdog; analog and flash off.
// RULE7: Power-down exits on the same wake source set as deep-sleep.
// RULE8: Watchdog oscillator and brownout detector may run through deep-sleep and power-down.
// RULE9: Deep power-down cuts power except wake pin logic and enabled timer.
// RULE10: Four retained registers keep contents through deep power-down.
// RULE11: Deep power-down exits on wake pin or self wake timer time-out.
// RULE12: Lock bit set refuses deep power-down entry.
// RULE13: Low pulse of at least 50 ns on wake pin ends deep power-down.
// RULE14: Mode entered only on wait-for-interrupt after software selects mode.
`include "lpm_consts.vh"
module low_power_mode_controller #(
    parameter NUM_SRC = 6,
    parameter WAKE_CYC = `WAKE_PULSE_CYC,
    parameter [31:0] SELF_WAKE_CYC = `SELF_WAKE_DEFAULT
) (
    input wire mclk,
    input wire srst,
    input wire wfi,
    input wire [1:0] mode_sel,
    input wire dpd_lock,
    input wire wdt_osc_keep,
    input wire brownout_keep,
    input wire self_wake_en,
    input wire [NUM_SRC-1:0] irq_in,
    input wire [NUM_SRC-1:0] wake_enable,
    input wire [NUM_SRC-1:0] irq_ctrl_enable,
    input wire any_irq,
    input wire wake_pin,
    input wire gp_wr_en,
    input wire [1:0] gp_wr_sel,
    input wire [31:0] gp_wr_data,
    input wire [1:0] gp_rd_sel,
    output wire [31:0] gp_rd_data,
    output reg cpu_run,
    output reg periph_clk_en,
    output reg internal_rc_oscillator_en,
    output reg rc_out_en,
    output reg wdt_osc_en,
    output reg brownout_detector_en,
    output reg analog_en,
    output reg flash_standby,
    output reg flash_power,
    output reg core_power,
    output reg [1:0] cur_mode,
    output reg in_low_power,
    output reg dpd_refused
);
    // ****************************************
    // States
    // ****************************************
    localparam ST_RUN = 3'h0;
    localparam ST_SLEEP = 3'h1;
    localparam ST_DSLEEP = 3'h2;
    localparam ST_PDOWN = 3'h3;
    localparam ST_DPD = 3'h4;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [NUM_SRC-1:0] irq_meta;
    reg [NUM_SRC-1:0] irq_sync;
    reg irq_any_meta;
    reg irq_any_sync;
    reg pin_meta;
    reg pin_sync;
    reg [7:0] low_cnt;
    reg [31:0] timer_cnt;
    wire enabled_wake;
    wire pin_wake;
    wire timer_wake;

    // ****************************************
    // Input synchronisers
    // ****************************************
    always @(posedge mclk)
    begin
        if (srst)
        begin
            irq_meta <= {NUM_SRC{1'b0}};
            irq_sync <= {NUM_SRC{1'b0}};
            irq_any_meta <= 1'b0;
            irq_any_sync <= 1'b0;
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end
        else
        begin
            irq_meta <= irq_in;
            irq_sync <= irq_meta;
            irq_any_meta <= any_irq;
            irq_any_sync <= irq_any_meta;
            pin_meta <= wake_pin;
            pin_sync <= pin_meta;
        end
    end

    // Only sources on the deep wake set, enabled in both places, count
    assign enabled_wake = |(irq_sync & wake_enable & irq_ctrl_enable); // RULE5 RULE4 RULE7

    // ****************************************
    // Wake pin low-pulse filter
    // ****************************************
    // The pin is only watched in deep power-down so glitches elsewhere are ignored
    always @(posedge mclk)
    begin
        if (srst)
            low_cnt <= 8'h00;
        else if (state != ST_DPD || pin_sync)
            low_cnt <= 8'h00;
        else if (low_cnt < WAKE_CYC[7:0])
            low_cnt <= low_cnt + 8'h01; // RULE13
    end
    assign pin_wake = (low_cnt >= WAKE_CYC[7:0]); // RULE13

    // ****************************************
    // Self wake-up timer
    // ****************************************
    always @(posedge mclk)
    begin
        if (srst)
            timer_cnt <= 32'h00000000;
        else if (state != ST_DPD || !self_wake_en)
            timer_cnt <= 32'h00000000;
        else if (timer_cnt < SELF_WAKE_CYC)
            timer_cnt <= timer_cnt + 32'h00000001;
    end
    assign timer_wake = self_wake_en && (timer_cnt >= SELF_WAKE_CYC); // RULE11

    // ****************************************
    // Mode sequencer
    // ****************************************
    always @*
    begin
        next_state = state;
        case (state)
            ST_RUN:
            begin
                if (wfi) // RULE14
                begin
                    case (mode_sel)
                        `MODE_SLEEP: next_state = ST_SLEEP;
                        `MODE_DEEP_SLEEP: next_state = ST_DSLEEP;
                        `MODE_POWER_DOWN: next_state = ST_PDOWN;
                        default: next_state = dpd_lock ? ST_RUN : ST_DPD; // RULE12
                    endcase
                end
            end
            ST_SLEEP:
                if (irq_any_sync)
                    next_state = ST_RUN; // RULE1
            ST_DSLEEP:
                if (enabled_wake)
                    next_state = ST_RUN; // RULE4
            ST_PDOWN:
                if (enabled_wake)
                    next_state = ST_RUN; // RULE7
            ST_DPD:
                if (pin_wake || timer_wake)
                    next_state = ST_RUN; // RULE11
            default:
                next_state = ST_RUN;
        endcase
    end

    always @(posedge mclk)
    begin
        if (srst)
        begin
            state <= ST_RUN;
            dpd_refused <= 1'b0;
        end
        else
        begin
            state <= next_state;
            // Sticky refusal flag; cleared by the next accepted entry
            if (state == ST_RUN && wfi && mode_sel == `MODE_DEEP_PD && dpd_lock)
                dpd_refused <= 1'b1; // RULE12
            else if (state == ST_RUN && wfi)
                dpd_refused <= 1'b0;
        end
    end

    // ****************************************
    // Domain gating
    // ****************************************
    always @(posedge mclk)
    begin
        if (srst)
        begin
            cpu_run <= 1'b1;
            periph_clk_en <= 1'b1;
            internal_rc_oscillator_en <= 1'b1;
            rc_out_en <= 1'b1;
            wdt_osc_en <= 1'b0;
            brownout_detector_en <= 1'b1;
            analog_en <= 1'b1;
            flash_standby <= 1'b0;
            flash_power <= 1'b1;
            core_power <= 1'b1;
            cur_mode <= `MODE_SLEEP;
            in_low_power <= 1'b0;
        end
        else
        begin
            cpu_run <= (next_state == ST_RUN); // RULE1
            in_low_power <= (next_state != ST_RUN);
            case (next_state)
                ST_SLEEP:
                begin
                    periph_clk_en <= 1'b1; // RULE1
                    internal_rc_oscillator_en <= 1'b1;
                    rc_out_en <= 1'b1;
                    wdt_osc_en <= wdt_osc_keep;
                    brownout_detector_en <= 1'b1;
                    analog_en <= 1'b1;
                    flash_standby <= 1'b0;
                    flash_power <= 1'b1;
                    core_power <= 1'b1;
                    cur_mode <= `MODE_SLEEP;
                end
                ST_DSLEEP:
                begin
                    periph_clk_en <= 1'b0; // RULE2
                    internal_rc_oscillator_en <= 1'b1; // RULE2
                    rc_out_en <= 1'b0; // RULE2
                    wdt_osc_en <= wdt_osc_keep; // RULE8
                    brownout_detector_en <= brownout_keep; // RULE8
                    analog_en <= 1'b0; // RULE3
                    flash_standby <= 1'b1; // RULE3
                    flash_power <= 1'b1; // RULE3
                    core_power <= 1'b1;
                    cur_mode <= `MODE_DEEP_SLEEP;
                end
                ST_PDOWN:
                begin
                    periph_clk_en <= 1'b0; // RULE6
                    internal_rc_oscillator_en <= 1'b0; // RULE6
                    rc_out_en <= 1'b0;
                    wdt_osc_en <= wdt_osc_keep; // RULE8
                    brownout_detector_en <= brownout_keep; // RULE8
                    analog_en <= 1'b0; // RULE6
                    flash_standby <= 1'b0;
                    flash_power <= 1'b0; // RULE6
                    core_power <= 1'b1;
                    cur_mode <= `MODE_POWER_DOWN;
                end
                ST_DPD:
                begin
                    // Everything off; the wake pin filter and timer stay on
                    periph_clk_en <= 1'b0; // RULE9
                    internal_rc_oscillator_en <= 1'b0;
                    rc_out_en <= 1'b0;
                    wdt_osc_en <= 1'b0;
                    brownout_detector_en <= 1'b0;
                    analog_en <= 1'b0;
                    flash_standby <= 1'b0;
                    flash_power <= 1'b0;
                    core_power <= 1'b0; // RULE9
                    cur_mode <= `MODE_DEEP_PD;
                end
                default:
                begin
                    periph_clk_en <= 1'b1;
                    internal_rc_oscillator_en <= 1'b1;
                    rc_out_en <= 1'b1;
                    wdt_osc_en <= wdt_osc_keep;
                    brownout_detector_en <= 1'b1;
                    analog_en <= 1'b1;
                    flash_standby <= 1'b0;
                    flash_power <= 1'b1;
                    core_power <= 1'b1;
                    cur_mode <= cur_mode;
                end
            endcase
        end
    end

    // ****************************************
    // Retained words
    // ****************************************
    retain_regs #(
        .WIDTH(32)
    ) u_retain (
        .mclk(mclk),
        .srst(srst),
        .wr_en(gp_wr_en),
        .wr_sel(gp_wr_sel),
        .wr_data(gp_wr_data),
        .rd_sel(gp_rd_sel),
        .rd_data(gp_rd_data)
    );
endmodule // low_power_mode_controller

/* lpm_consts.vh */
/*
 Shared constants for the low-power mode controller: mode codes,
 retained register count and wake pin pulse timing.
 Assumes a 50 MHz system clock on mclk.
*/
`ifndef LPM_CONSTS_VH
`define LPM_CONSTS_VH
// ****************************************
// Mode selection codes
// ****************************************
`define MODE_SLEEP 2'h0
`define MODE_DEEP_SLEEP 2'h1
`define MODE_POWER_DOWN 2'h2
`define MODE_DEEP_PD 2'h3
// ****************************************
// Retention and timing
// ****************************************
`define RETAIN_REGS 4
`define CLK_PERIOD_NS 20
`define WAKE_PULSE_NS 50
// Rounds down: an asynchronous pulse of the least legal width may span only this many edges
`define WAKE_PULSE_CYC (`WAKE_PULSE_NS / `CLK_PERIOD_NS)
`define SELF_WAKE_DEFAULT 32'h00001000
`endif

/* retain_regs.v */
/*
 Four general-purpose words that survive deep power-down.
 Assumes they sit in the always-on domain and are cleared by reset only.
*/
`include "lpm_consts.vh"
module retain_regs #(
    parameter WIDTH = 32
) (
    input wire mclk,
    input wire srst,
    input wire wr_en,
    input wire [1:0] wr_sel,
    input wire [WIDTH-1:0] wr_data,
    input wire [1:0] rd_sel,
    output reg [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] store [0:`RETAIN_REGS-1];
    integer i;
    // ****************************************
    // Storage
    // ****************************************
    always @(posedge mclk)
    begin
        if (srst)
        begin
            for (i = 0; i < `RETAIN_REGS; i = i + 1)
                store[i] <= {WIDTH{1'b0}};
            rd_data <= {WIDTH{1'b0}};
        end
        else
        begin
            if (wr_en)
                store[wr_sel] <= wr_data; // RULE10
            rd_data <= store[rd_sel];
        end
    end
endmodule // retain_regs

/* lpm_chk.sv */
/* Checker for the low-power mode controller: entry, lock and wake timing.
   Bound to the controller top; sees its ports only. */
module lpm_chk #(
    parameter NUM_SRC = 6
) (
    input wire mclk,
    input wire srst,
    input wire wfi,
    input wire [1:0] mode_sel,
    input wire dpd_lock,
    input wire [NUM_SRC-1:0] irq_in,
    input wire [NUM_SRC-1:0] wake_enable,
    input wire [NUM_SRC-1:0] irq_ctrl_enable,
    input wire any_irq,
    input wire wake_pin,
    input wire cpu_run,
    input wire periph_clk_en,
    input wire internal_rc_oscillator_en,
    input wire rc_out_en,
    input wire analog_en,
    input wire flash_standby,
    input wire flash_power,
    input wire core_power,
    input wire [1:0] cur_mode,
    input wire in_low_power,
    input wire dpd_refused
);
timeunit 1ns;
timeprecision 1ns;
wire go = wfi && cpu_run;
wire gw = |(irq_in & wake_enable & irq_ctrl_enable);
wire deep = in_low_power && cur_mode[1] != cur_mode[0];
default clocking cb @(posedge mclk);
endclocking
default disable iff (srst);
// ****
// Entry and wake
// ****
chk_sleep_entry:
    assert property (go && mode_sel == 2'h0 |=> !cpu_run && periph_clk_en && cur_mode == 2'h0)
    else $error("bad sleep entry");
chk_deep_entry:
    assert property (go && mode_sel == 2'h1 |=> !periph_clk_en && internal_rc_oscillator_en
        && !rc_out_en && !analog_en && flash_standby && cur_mode == 2'h1)
    else $error("bad deep-sleep entry");
chk_pd_entry:
    assert property (go && mode_sel == 2'h2 |=> !periph_clk_en && !internal_rc_oscillator_en
        && !analog_en && !flash_power && cur_mode == 2'h2)
    else $error("bad power-down entry");
chk_dpd_entry:
    assert property (go && mode_sel == 2'h3 && !dpd_lock |=> !core_power && cur_mode == 2'h3)
    else $error("bad deep power-down entry");
chk_dpd_lock:
    assert property (go && mode_sel == 2'h3 && dpd_lock |=> cpu_run && dpd_refused)
    else $error("locked entry taken");
chk_entry_cause:
    assert property ($fell(cpu_run) |-> $past(go))
    else $error("halt without request");
chk_lp_wfi:
    assert property (in_low_power && wfi |=> cpu_run || cur_mode == $past(cur_mode))
    else $error("request taken in low power");
chk_deep_wake:
    assert property (deep && gw |-> ##[0:4] cpu_run)
    else $error("enabled source did not wake");
chk_no_stray:
    assert property (deep && !gw && !$past(gw) && !$past(gw, 2) && !$past(gw, 3) |=> !cpu_run)
    else $error("woke without enabled source");
chk_sleep_hold:
    assert property (in_low_power && cur_mode == 2'h0 && !any_irq && !$past(any_irq)
        && !$past(any_irq, 2) && !$past(any_irq, 3) |=> !cpu_run)
    else $error("sleep left without interrupt");
chk_pin_wake:
    assert property ((in_low_power && cur_mode == 2'h3 && !wake_pin) [*3] |-> ##[0:6] cpu_run)
    else $error("wake pin ignored");
endmodule // lpm_chk
bind low_power_mode_controller lpm_chk #(.NUM_SRC(NUM_SRC)) u_chk (.*);

/* lpm_far_side.sv */
/* Far side: interrupt sources and the wake pin.
   Bench commands change between clock edges; the pin is pulled up. */
module lpm_far_side (
    input wire [2:0] src,
    input wire fire,
    input wire pin_low,
    output logic [5:0] irq_in,
    output logic any_irq,
    output logic wake_pin
);
timeunit 1ns;
timeprecision 1ns;
// ****
// Sources
// ****
// Level held until the bench sees the core awake
assign irq_in = fire ? 6'h01 << src : 6'h00;
assign any_irq = fire;
assign wake_pin = !pin_low;
endmodule // lpm_far_side

/* tb_low_power_mode_controller.sv */
/* Bench for the low-power mode controller with the far-side model.
   Assumes a 50 MHz mclk; self wake count shortened to 20 cycles. */
module tb_low_power_mode_controller;
timeunit 1ns;
timeprecision 1ns;
logic mclk = 0, srst = 1, wfi = 0, dpd_lock = 0, wdt_osc_keep = 0, brownout_keep = 0;
logic self_wake_en = 0, gp_wr_en = 0, fire = 0, pin_low = 0;
logic [1:0] mode_sel = 0, gp_wr_sel = 0, gp_rd_sel = 0;
logic [2:0] src = 0;
logic [5:0] wake_enable = 0, irq_ctrl_enable = 0, irq_in;
logic [31:0] gp_wr_data = 0, gp_rd_data;
logic any_irq, wake_pin, cpu_run, periph_clk_en, internal_rc_oscillator_en, rc_out_en;
logic wdt_osc_en, brownout_detector_en, analog_en, flash_standby, flash_power, core_power;
logic in_low_power, dpd_refused;
logic [1:0] cur_mode;
logic [1:0] last_md = 0;
logic [31:0] words [4];
int n_fail = 0, num_checks = 0, k;
wire [10:0] obs = {cpu_run, periph_clk_en, internal_rc_oscillator_en, rc_out_en, analog_en,
    flash_standby, flash_power, core_power, cur_mode, in_low_power};
always #10 mclk = ~mclk;
low_power_mode_controller #(.SELF_WAKE_CYC(32'h14)) uut (.*);
lpm_far_side far (.*);
// ****
// Helpers
// ****
// Mask and value per state; 4 is running
function automatic logic [21:0] want(input int s);
    case (s)
        0: return {11'h7ff, 11'h3d9};
        1: return {11'h7ff, 11'h13b};
        2: return {11'h7ff, 11'h00d};
        3: return {11'h7ff, 11'h007};
        // Running shows the last mode that was entered
        default: return {11'h7ff, 11'h7d8 | {8'h00, last_md, 1'b0}};
    endcase
endfunction
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
        n_fail++;
        $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic look(input int s);
    logic [21:0] w;
    w = want(s);
    check(obs & w[21:11], w[10:0]);
endtask
task automatic enter(input logic [1:0] md);
    @(negedge mclk);
    mode_sel = md;
    wfi = 1'b1;
    if (cpu_run === 1'b1 && !(md == 2'h3 && dpd_lock))
        last_md = md;
    @(negedge mclk);
    wfi = 1'b0;
endtask
task automatic wait_run(input int lim);
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n < lim)
    begin
        @(negedge mclk);
        n++;
    end
endtask
task automatic test_done;
    if (n_fail == 0 && num_checks > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
// ****
// Tests
// ****
initial
begin
    #100000;
    n_fail++;
    test_done;
end
initial
begin
    k = $urandom(32'h9fdbb51d);
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    look(4);
    check(gp_rd_data, 32'h0);
    enter(2'h0);
    look(0);
    enter(2'h1);
    repeat (4) @(negedge mclk);
    look(0);
    fire = 1'b1;
    wait_run(6);
    look(4);
    fire = 1'b0;
    for (k = 0; k < 12; k++)
    begin
        src = 3'($urandom % 6);
        wake_enable = 6'($urandom) | (6'h01 << src);
        irq_ctrl_enable = 6'($urandom) | (6'h01 << src);
        // Alternate every two passes which of the two enables is missing
        if (k[1])
            wake_enable[src] = 1'b0;
        else
            irq_ctrl_enable[src] = 1'b0;
        wdt_osc_keep = 1'($urandom);
        brownout_keep = 1'($urandom);
        enter(2'(k % 2 + 1));
        look(k % 2 + 1);
        check({wdt_osc_en, brownout_detector_en}, {wdt_osc_keep, brownout_keep});
        fire = 1'b1;
        repeat (6) @(negedge mclk);
        check(cpu_run, 1'b0);
        wake_enable[src] = 1'b1;
        irq_ctrl_enable[src] = 1'b1;
        wait_run(6);
        look(4);
        fire = 1'b0;
        @(negedge mclk);
    end
    gp_wr_en = 1'b1;
    for (k = 0; k < 4; k++)
    begin
        words[k] = $urandom;
        gp_wr_sel = 2'(k);
        gp_wr_data = words[k];
        @(negedge mclk);
    end
    gp_wr_en = 1'b0;
    dpd_lock = 1'b1;
    enter(2'h3);
    look(4);
    check(dpd_refused, 1'b1);
    dpd_lock = 1'b0;
    enter(2'h3);
    look(3);
    check(dpd_refused, 1'b0);
    repeat (4) @(negedge mclk);
    pin_low = 1'b1;
    repeat (3) @(negedge mclk);
    pin_low = 1'b0;
    wait_run(8);
    look(4);
    for (k = 0; k < 4; k++)
    begin
        gp_rd_sel = 2'(k);
        repeat (2) @(negedge mclk);
        check(gp_rd_data, words[k]);
    end
    self_wake_en = 1'b1;
    enter(2'h3);
    repeat (10) @(negedge mclk);
    check(cpu_run, 1'b0);
    wait_run(20);
    look(4);
    test_done;
end
endmodule // tb_low_power_mode_controller
